// ==== hsts_regs.svh ====
// constants for host interface strap select
//
// Notes on behaviour
// RQ1 - capture both protocol straps and boot strap at reset; decode from captured values
// RQ2 - boot high: codes 00 I2C, 01 robot UART, 10 packet UART, 11 SPI
// RQ3 - boot low: bootloader mode, same decode but code 01 reserved
// RQ4 - in SPI mode the low protocol pin becomes the host wake input
// RQ5 - clock source: first strap 0 crystal; 1,1 external; 1,0 internal oscillator
// RQ6 - first clock strap pull-down on at startup, off after sampling a 1
// RQ7 - second clock strap used as pulled-down input only if first read 1
// RQ8 - second clock strap pull-down off after sampling a 1
// RQ9 - board must not pair internal oscillator with either UART mode
// RQ10 - external clock choice needs a 32.768 kHz clock from outside
// RQ11 - I2C mode runs as fast-mode target, up to 400 kb/s
// RQ12 - host interrupt driven low when the device needs host attention
// RQ13 - address-select strap sets lsb of the 7-bit I2C target address
// RQ14 - device held in reset while reset input is low
// RQ15 - auxiliary sensor bus is polled once after reset
// RQ16 - SPI chip select is active low; transfers only while low
// RQ17 - host data pin is I2C data, SPI serial out or UART transmit
// RQ18 - host clock pin is I2C clock, SPI clock or UART receive
// RQ19 - address-select pin is SPI serial data input in SPI mode
// RQ20 - I2C target address is 0x4A or 0x4B by address strap
// RQ21 - address-select pin captured at reset, tied fixed by the board
// RQ22 - captured straps hold until next reset, wake input excepted
// RQ23 - reserved bootloader code enables no interface, host pins undriven
`ifndef HSTS_REGS_SVH
`define HSTS_REGS_SVH
`define HSTS_CLK_MHZ 200
`define HSTS_SETTLE_NS 1000
`define HSTS_SETTLE_CYC ((`HSTS_SETTLE_NS * `HSTS_CLK_MHZ + 999) / 1000)
`define HSTS_SETTLE_LAST 8'(`HSTS_SETTLE_CYC - 1)
`define HSTS_I2C_MAX_KBPS 400
`define HSTS_I2C_MIN_BIT_CYC 10'((`HSTS_CLK_MHZ * 1000 + `HSTS_I2C_MAX_KBPS - 1) / `HSTS_I2C_MAX_KBPS)
`define HSTS_I2C_ADDR_HI 6'h25
`define HSTS_CODE_RSVD 2'h1
`define HSTS_PIN_IDLE '{o: 1'b0, oe: 1'b0}
`define HSTS_STRAP_RST '{mode: HSTS_NONE, boot: 1'b0, lsb: 1'b0, done: 1'b0}
`define HSTS_CLK_RST '{state: CS_SETTLE_A, cnt: 8'h00, pd_a: 1'b1, pd_b: 1'b0, \
  xtal: 1'b0, src: HSTS_SRC_UNK, done: 1'b0}
`define HSTS_TOP_RST '{data: `HSTS_PIN_IDLE, clk: `HSTS_PIN_IDLE, irq_n: 1'b1, \
  wake: 1'b0, spi_sel: 1'b0, i2c_sda: 1'b1, i2c_scl: 1'b1, spi_sck: 1'b0, \
  spi_mosi: 1'b0, uart_rx: 1'b1, i2c_addr: 7'h00, i2c_bit: 10'h000, poll: 1'b0, \
  polled: 1'b0, conflict: 1'b0}
`endif

// ==== hsts_pkg.sv ====
// types for host interface strap select
package hsts_pkg;
  typedef enum logic [2:0] {
    HSTS_I2C    = 3'b000,
    HSTS_ROBOT  = 3'b001,
    HSTS_PACKET = 3'b010,
    HSTS_SPI    = 3'b011,
    HSTS_NONE   = 3'b100
  } hsts_mode_e;
  typedef enum logic [1:0] {
    HSTS_SRC_XTAL = 2'b00,
    HSTS_SRC_EXT  = 2'b01,
    HSTS_SRC_INT  = 2'b10,
    HSTS_SRC_UNK  = 2'b11
  } hsts_clk_e;
  typedef enum logic [1:0] {
    CS_SETTLE_A = 2'b00,
    CS_SETTLE_B = 2'b01,
    CS_DONE     = 2'b10
  } hsts_cst_e;
  typedef struct packed {
    logic o;
    logic oe;
  } hsts_pin_s;
  typedef struct packed {
    hsts_mode_e mode;
    logic       boot;
    logic       lsb;
    logic       done;
  } hsts_strap_s;
  typedef struct packed {
    hsts_cst_e  state;
    logic [7:0] cnt;
    logic       pd_a;
    logic       pd_b;
    logic       xtal;
    hsts_clk_e  src;
    logic       done;
  } hsts_clk_s;
  typedef struct packed {
    hsts_pin_s  data;
    hsts_pin_s  clk;
    logic       irq_n;
    logic       wake;
    logic       spi_sel;
    logic       i2c_sda;
    logic       i2c_scl;
    logic       spi_sck;
    logic       spi_mosi;
    logic       uart_rx;
    logic [6:0] i2c_addr;
    logic [9:0] i2c_bit;
    logic       poll;
    logic       polled;
    logic       conflict;
  } hsts_top_s;
endpackage

// ==== hsts_strap_cap.sv ====
// one-shot capture and decode of protocol, boot and address straps
`timescale 1ns/100ps
`include "hsts_regs.svh"
module hsts_strap_cap import hsts_pkg::*; (
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  // strap pins
  input  wire logic  hi_i,
  input  wire logic  lo_i,
  input  wire logic  boot_n_i,
  input  wire logic  lsb_i,
  // captured straps
  output hsts_strap_s strap_o
);
  hsts_strap_s st;
  hsts_strap_s next_st;
  logic [1:0]  code;

  always_comb begin
    code    = {hi_i, lo_i};
    next_st = st;
    // async reset cannot load pins, so capture on the first edge after release
    if (!st.done) begin // RQ1
      next_st.done = 1'b1;
      next_st.boot = !boot_n_i;
      next_st.lsb  = lsb_i; // RQ21
      next_st.mode = hsts_mode_e'({1'b0, code}); // RQ2
      if (!boot_n_i && code == `HSTS_CODE_RSVD) begin
        next_st.mode = HSTS_NONE; // RQ3 RQ23
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= `HSTS_STRAP_RST; // RQ14
    end else begin
      st <= next_st; // RQ22
    end
  end

  assign strap_o = st;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_strap_hold: assert property (st.done |=> $stable(st)) // RQ22
    else $error("captured straps changed after capture");
  a_normal_decode: assert property (!st.done && boot_n_i |=> // RQ2
    st.mode == hsts_mode_e'({1'b0, $past(hi_i), $past(lo_i)}))
    else $error("normal mode strap decode wrong");
  a_rsvd_code: assert property (!st.done && !boot_n_i && {hi_i, lo_i} == `HSTS_CODE_RSVD // RQ3
    |=> st.mode == HSTS_NONE && st.boot)
    else $error("reserved bootloader code not refused");
endmodule

// ==== hsts_clk_sel.sv ====
// clock source strap sequencing with pull-down control
`timescale 1ns/100ps
`include "hsts_regs.svh"
module hsts_clk_sel import hsts_pkg::*; (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // clock select straps
  input  wire logic sel_a_i,
  input  wire logic sel_b_i,
  // result
  output hsts_clk_s clk_o
);
  hsts_clk_s st;
  hsts_clk_s next_st;

  always_comb begin
    next_st = st;
    case (st.state)
      CS_SETTLE_A: begin
        // let the pull-down settle before trusting the pin
        next_st.cnt = st.cnt + 8'h01;
        if (st.cnt == `HSTS_SETTLE_LAST) begin
          next_st.cnt = 8'h00;
          if (sel_a_i) begin
            next_st.pd_a  = 1'b0; // RQ6
            next_st.pd_b  = 1'b1; // RQ7
            next_st.state = CS_SETTLE_B;
          end else begin
            next_st.src   = HSTS_SRC_XTAL; // RQ5
            next_st.xtal  = 1'b1;
            next_st.done  = 1'b1;
            next_st.state = CS_DONE;
          end
        end
      end
      CS_SETTLE_B: begin
        next_st.cnt = st.cnt + 8'h01;
        if (st.cnt == `HSTS_SETTLE_LAST) begin
          next_st.src   = sel_b_i ? HSTS_SRC_EXT : HSTS_SRC_INT; // RQ5
          next_st.pd_b  = !sel_b_i; // RQ8
          next_st.done  = 1'b1;
          next_st.state = CS_DONE;
        end
      end
      CS_DONE: begin
        next_st.cnt = 8'h00;
      end
      default: begin
        next_st = `HSTS_CLK_RST;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= `HSTS_CLK_RST; // RQ6
    end else begin
      st <= next_st;
    end
  end

  assign clk_o = st;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_a_high;
    st.state == CS_SETTLE_A && st.cnt == `HSTS_SETTLE_LAST && sel_a_i;
  endsequence
  sequence s_b_high;
    st.state == CS_SETTLE_B && st.cnt == `HSTS_SETTLE_LAST && sel_b_i;
  endsequence

  a_pd_a_release: assert property (s_a_high |=> !st.pd_a && st.pd_b) // RQ6
    else $error("first pull-down not released after a high sample");
  a_b_needs_a: assert property (st.done && st.src == HSTS_SRC_XTAL |-> !st.pd_b && st.pd_a) // RQ7
    else $error("second strap touched in crystal mode");
  a_pd_b_release: assert property (s_b_high |=> !st.pd_b && st.src == HSTS_SRC_EXT) // RQ8
    else $error("second pull-down not released after a high sample");
endmodule

// ==== hsts_top.sv ====
// host interface strap select and shared host pin routing
`timescale 1ns/100ps
`include "hsts_regs.svh"
module hsts_top import hsts_pkg::*; (
  // clock and reset
  input  wire logic       MCLK_I,
  input  wire logic       RST_N_I,
  // strap and select pins
  input  wire logic       PROTO_SEL_HI_I,
  input  wire logic       PROTO_SEL_LO_OR_WAKE_I,
  input  wire logic       BOOT_LOADER_SEL_N_I,
  input  wire logic       ADDR_LSB_OR_SERIAL_IN_I,
  input  wire logic       CLK_SRC_SEL_A_I,
  input  wire logic       SLOW_XTAL_OUT_OR_SEL_B_I,
  input  wire logic       HOST_CHIP_SEL_N_I,
  // shared host pins
  input  wire logic       HOST_DATA_I,
  output logic            HOST_DATA_O,
  output logic            HOST_DATA_OE_O,
  input  wire logic       HOST_CLK_I,
  output logic            HOST_CLK_O,
  output logic            HOST_CLK_OE_O,
  output logic            HOST_IRQ_N_O,
  // protocol engine side
  input  wire logic       IRQ_REQ_I,
  input  wire logic       I2C_SDA_LOW_I,
  input  wire logic       I2C_SCL_LOW_I,
  input  wire logic       SPI_MISO_I,
  input  wire logic       UART_TX_I,
  output logic            I2C_SDA_O,
  output logic            I2C_SCL_O,
  output logic            SPI_SCK_O,
  output logic            SPI_MOSI_O,
  output logic            SPI_SEL_O,
  output logic            UART_RX_O,
  output logic            WAKE_O,
  // configuration and status
  output hsts_mode_e      MODE_O,
  output logic            BOOT_LOADER_O,
  output logic [6:0]      I2C_ADDR_O,
  output logic [9:0]      I2C_BIT_CYC_O,
  output hsts_clk_e       CLK_SRC_O,
  output logic            CLK_SRC_VALID_O,
  output logic            PD_A_EN_O,
  output logic            PD_B_EN_O,
  output logic            XTAL_EN_O,
  output logic            AUX_POLL_START_O,
  output logic            CFG_CONFLICT_O
);
  hsts_top_s   st;
  hsts_top_s   next_st;
  hsts_strap_s strap;
  hsts_clk_s   csel;
  logic        is_uart;
  logic        ready;

  hsts_strap_cap u_strap (
    .clk_i    (MCLK_I),
    .rst_n_i  (RST_N_I),
    .hi_i     (PROTO_SEL_HI_I),
    .lo_i     (PROTO_SEL_LO_OR_WAKE_I),
    .boot_n_i (BOOT_LOADER_SEL_N_I),
    .lsb_i    (ADDR_LSB_OR_SERIAL_IN_I),
    .strap_o  (strap)
  );

  hsts_clk_sel u_clk (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .sel_a_i (CLK_SRC_SEL_A_I),
    .sel_b_i (SLOW_XTAL_OUT_OR_SEL_B_I),
    .clk_o   (csel)
  );

  always_comb begin
    is_uart = strap.mode == HSTS_ROBOT || strap.mode == HSTS_PACKET;
    ready   = strap.done && csel.done;
    next_st = st;
    // idle levels each cycle so a deselected engine sees a quiet bus
    next_st.data     = `HSTS_PIN_IDLE;
    next_st.clk      = `HSTS_PIN_IDLE;
    next_st.wake     = 1'b0;
    next_st.spi_sel  = 1'b0;
    next_st.i2c_sda  = 1'b1;
    next_st.i2c_scl  = 1'b1;
    next_st.spi_sck  = 1'b0;
    next_st.spi_mosi = 1'b0;
    next_st.uart_rx  = 1'b1;
    next_st.i2c_addr = 7'h00;
    next_st.i2c_bit  = 10'h000;
    next_st.poll     = 1'b0;
    case (strap.mode)
      HSTS_I2C: begin
        // open drain: only ever pull low, the board pull-ups make the high
        next_st.data.oe  = I2C_SDA_LOW_I; // RQ17
        next_st.clk.oe   = I2C_SCL_LOW_I; // RQ18
        next_st.i2c_sda  = HOST_DATA_I;
        next_st.i2c_scl  = HOST_CLK_I;
        next_st.i2c_addr = {`HSTS_I2C_ADDR_HI, strap.lsb}; // RQ13 RQ20
        next_st.i2c_bit  = `HSTS_I2C_MIN_BIT_CYC; // RQ11
      end
      HSTS_SPI: begin
        next_st.spi_sel  = !HOST_CHIP_SEL_N_I; // RQ16
        next_st.data.o   = SPI_MISO_I; // RQ17
        next_st.data.oe  = !HOST_CHIP_SEL_N_I; // RQ16
        next_st.spi_sck  = HOST_CLK_I; // RQ18
        next_st.spi_mosi = ADDR_LSB_OR_SERIAL_IN_I; // RQ19
        next_st.wake     = PROTO_SEL_LO_OR_WAKE_I; // RQ4
      end
      HSTS_ROBOT, HSTS_PACKET: begin
        next_st.data.o  = UART_TX_I; // RQ17
        next_st.data.oe = 1'b1;
        next_st.uart_rx = HOST_CLK_I; // RQ18
      end
      default: begin
        next_st.data = `HSTS_PIN_IDLE; // RQ23
        next_st.clk  = `HSTS_PIN_IDLE;
      end
    endcase
    // masked until straps are known, so reset glitches never reach the host
    next_st.irq_n = !(strap.done && IRQ_REQ_I); // RQ12
    if (ready && !st.polled) begin
      next_st.poll   = 1'b1; // RQ15
      next_st.polled = 1'b1;
    end
    // flags a board fault only; the interface is still enabled as strapped
    next_st.conflict = csel.done && csel.src == HSTS_SRC_INT && is_uart; // RQ9
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st <= `HSTS_TOP_RST; // RQ14
    end else begin
      st <= next_st;
    end
  end

  assign HOST_DATA_O      = st.data.o;
  assign HOST_DATA_OE_O   = st.data.oe;
  assign HOST_CLK_O       = st.clk.o;
  assign HOST_CLK_OE_O    = st.clk.oe;
  assign HOST_IRQ_N_O     = st.irq_n;
  assign I2C_SDA_O        = st.i2c_sda;
  assign I2C_SCL_O        = st.i2c_scl;
  assign SPI_SCK_O        = st.spi_sck;
  assign SPI_MOSI_O       = st.spi_mosi;
  assign SPI_SEL_O        = st.spi_sel;
  assign UART_RX_O        = st.uart_rx;
  assign WAKE_O           = st.wake;
  assign MODE_O           = strap.mode;
  assign BOOT_LOADER_O    = strap.boot;
  assign I2C_ADDR_O       = st.i2c_addr;
  assign I2C_BIT_CYC_O    = st.i2c_bit;
  assign CLK_SRC_O        = csel.src;
  assign CLK_SRC_VALID_O  = csel.done;
  assign PD_A_EN_O        = csel.pd_a;
  assign PD_B_EN_O        = csel.pd_b;
  assign XTAL_EN_O        = csel.xtal;
  assign AUX_POLL_START_O = st.poll;
  assign CFG_CONFLICT_O   = st.conflict;

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_init_done;
    strap.done && csel.done && !st.polled;
  endsequence
  sequence s_spi_idle;
    strap.mode == HSTS_SPI && HOST_CHIP_SEL_N_I;
  endsequence

  a_irq_assert: assert property (strap.done && IRQ_REQ_I |=> !HOST_IRQ_N_O) // RQ12
    else $error("host interrupt not driven low on request");
  a_irq_quiet: assert property (!strap.done |=> HOST_IRQ_N_O) // RQ12
    else $error("host interrupt active before straps known");
  a_i2c_addr: assert property (strap.mode == HSTS_I2C |=> // RQ20
    I2C_ADDR_O == {`HSTS_I2C_ADDR_HI, strap.lsb})
    else $error("i2c target address wrong");
  a_i2c_rate: assert property (strap.mode == HSTS_I2C |=> I2C_BIT_CYC_O == `HSTS_I2C_MIN_BIT_CYC) // RQ11
    else $error("i2c bit period limit wrong");
  a_i2c_open_drain: assert property (strap.mode == HSTS_I2C |=> // RQ17
    !HOST_DATA_O && HOST_DATA_OE_O == $past(I2C_SDA_LOW_I))
    else $error("i2c data pin not open drain");
  a_spi_cs_idle: assert property (s_spi_idle |=> !HOST_DATA_OE_O && !SPI_SEL_O) // RQ16
    else $error("spi output driven while deselected");
  a_spi_wake: assert property (strap.mode == HSTS_SPI |=> WAKE_O == $past(PROTO_SEL_LO_OR_WAKE_I)) // RQ4
    else $error("wake input not followed in spi mode");
  a_spi_mosi: assert property (strap.mode == HSTS_SPI |=> // RQ19
    SPI_MOSI_O == $past(ADDR_LSB_OR_SERIAL_IN_I) && SPI_SCK_O == $past(HOST_CLK_I))
    else $error("spi input routing wrong");
  a_uart_tx: assert property (is_uart |=> HOST_DATA_OE_O && HOST_DATA_O == $past(UART_TX_I)) // RQ17
    else $error("uart transmit routing wrong");
  a_uart_rx: assert property (is_uart |=> UART_RX_O == $past(HOST_CLK_I) && !HOST_CLK_OE_O) // RQ18
    else $error("uart receive routing wrong");
  a_rsvd_quiet: assert property (strap.done && strap.mode == HSTS_NONE |=> // RQ23
    !HOST_DATA_OE_O && !HOST_CLK_OE_O && !SPI_SEL_O)
    else $error("host pins driven with no interface");
  a_aux_poll: assert property (s_init_done |=> AUX_POLL_START_O ##1 !AUX_POLL_START_O) // RQ15
    else $error("aux bus poll start not a single pulse");
  a_conflict: assert property (csel.done && csel.src == HSTS_SRC_INT && is_uart |=> CFG_CONFLICT_O) // RQ9
    else $error("clock and uart strap conflict not flagged");
endmodule

// ==== hsts_host_model.sv ====
// host and board model: clock straps with pull-downs and shared host pins
`timescale 1ns/100ps
module hsts_host_model (
  // clock
  input  wire logic       clk_i,
  // board strap wiring: 0 tied low, 1 tied high, 2 open
  input  wire logic [1:0] a_cfg_i,
  input  wire logic [1:0] b_cfg_i,
  // device pad controls
  input  wire logic       pd_a_i,
  input  wire logic       pd_b_i,
  input  wire logic       xtal_i,
  input  wire logic       data_o_i,
  input  wire logic       data_oe_i,
  input  wire logic       clk_o_i,
  input  wire logic       clk_oe_i,
  // host drive of the clock pin
  input  wire logic       host_drv_i,
  input  wire logic       host_val_i,
  // pin levels
  output logic            sel_a_o,
  output logic            sel_b_o,
  output logic            data_line_o,
  output logic            clk_line_o
);
  logic last_a   = 1'h0;
  logic last_b   = 1'h0;
  logic slow_clk = 1'h0;
  // plain always: the float model needs a known start value from the declaration
  always @(posedge clk_i) begin
    last_a <= sel_a_o;
    last_b <= sel_b_o;
  end
  // an open strap without its pull-down floats; model it as a toggling level
  always_comb begin
    sel_a_o = (a_cfg_i == 2'h2) ? (!pd_a_i && !last_a) : a_cfg_i[0];
    if (xtal_i) begin
      sel_b_o = !last_b;
    end else begin
      sel_b_o = (b_cfg_i == 2'h2) ? (!pd_b_i && !last_b) : b_cfg_i[0];
    end
  end
  // slow clock only when the straps ask for an external source
  always #15259 slow_clk = (a_cfg_i == 2'h1 && b_cfg_i == 2'h1) ? !slow_clk : 1'h0;
  // board pull-ups on both host lines; wired-and with the host on the clock pin
  assign data_line_o = data_oe_i ? data_o_i : 1'h1;
  assign clk_line_o  = (clk_oe_i ? clk_o_i : 1'h1) & (host_drv_i ? host_val_i : 1'h1);
endmodule

// ==== hsts_top_tb.sv ====
// self-checking bench for strap capture, clock source choice and pin routing
`timescale 1ns/100ps
module hsts_top_tb;
  import hsts_pkg::*;
  logic       MCLK_I  = 1'h0;
  logic       RST_N_I = 1'h0;
  logic       hi = 1'h0, lo = 1'h0, boot_n = 1'h1, lsb = 1'h0, cs_n = 1'h1;
  logic       irq = 1'h0, sda_low = 1'h0, scl_low = 1'h0, miso = 1'h0, tx = 1'h1;
  logic       hdrv = 1'h0, hval = 1'h1;
  logic [1:0] a_cfg = 2'h2, b_cfg = 2'h2;
  logic       sel_a, sel_b, data_line, clk_line;
  logic       data_o, data_oe, clk_o, clk_oe, irq_n, sda_o, scl_o, sck_o, mosi_o;
  logic       spi_sel, rx_o, wake_o, boot_o, src_valid, pd_a, pd_b, xtal, poll, conflict;
  hsts_mode_e mode;
  hsts_clk_e  src;
  logic [6:0] addr;
  logic [9:0] bitcyc;
  int         fail_count  = 0;
  int         comparisons = 0;
  int         cycles      = 0;
  int         polls       = 0;
  // strap table {hi, lo, boot_n, lsb, a_cfg, b_cfg}; last entry pairs internal clock with uart
  logic [7:0] cases [10] = '{8'h2A, 8'h35, 8'h60, 8'hA5, 8'hF6, 8'h14, 8'h4A, 8'h9A, 8'hC5,
                             8'hA4};

  hsts_top dut (
    .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .PROTO_SEL_HI_I(hi), .PROTO_SEL_LO_OR_WAKE_I(lo),
    .BOOT_LOADER_SEL_N_I(boot_n), .ADDR_LSB_OR_SERIAL_IN_I(lsb), .CLK_SRC_SEL_A_I(sel_a),
    .SLOW_XTAL_OUT_OR_SEL_B_I(sel_b), .HOST_CHIP_SEL_N_I(cs_n), .HOST_DATA_I(data_line),
    .HOST_DATA_O(data_o), .HOST_DATA_OE_O(data_oe), .HOST_CLK_I(clk_line),
    .HOST_CLK_O(clk_o), .HOST_CLK_OE_O(clk_oe), .HOST_IRQ_N_O(irq_n), .IRQ_REQ_I(irq),
    .I2C_SDA_LOW_I(sda_low), .I2C_SCL_LOW_I(scl_low), .SPI_MISO_I(miso), .UART_TX_I(tx),
    .I2C_SDA_O(sda_o), .I2C_SCL_O(scl_o), .SPI_SCK_O(sck_o), .SPI_MOSI_O(mosi_o),
    .SPI_SEL_O(spi_sel), .UART_RX_O(rx_o), .WAKE_O(wake_o), .MODE_O(mode),
    .BOOT_LOADER_O(boot_o), .I2C_ADDR_O(addr), .I2C_BIT_CYC_O(bitcyc), .CLK_SRC_O(src),
    .CLK_SRC_VALID_O(src_valid), .PD_A_EN_O(pd_a), .PD_B_EN_O(pd_b), .XTAL_EN_O(xtal),
    .AUX_POLL_START_O(poll), .CFG_CONFLICT_O(conflict)
  );

  hsts_host_model host (
    .clk_i(MCLK_I), .a_cfg_i(a_cfg), .b_cfg_i(b_cfg), .pd_a_i(pd_a), .pd_b_i(pd_b),
    .xtal_i(xtal), .data_o_i(data_o), .data_oe_i(data_oe), .clk_o_i(clk_o),
    .clk_oe_i(clk_oe), .host_drv_i(hdrv), .host_val_i(hval), .sel_a_o(sel_a),
    .sel_b_o(sel_b), .data_line_o(data_line), .clk_line_o(clk_line)
  );

  initial forever #2.5 MCLK_I = !MCLK_I;

  // run ceiling far above ten resets of at most about 420 cycles each
  always @(posedge MCLK_I) begin
    cycles++;
    if (poll === 1'h1) polls++;
    if (cycles == 20000) begin
      fail_count++;
      $display("[FAIL] %0t run timed out", $time);
      report_and_stop();
    end
  end

  task automatic step(input int n);
    repeat (n) begin
      @(posedge MCLK_I);
      #1;
    end
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic run_case(input logic [7:0] cfg);
    logic       h, l, bn, lb, uart, spi;
    logic [1:0] ac, bc;
    hsts_mode_e em;
    hsts_clk_e  es;
    int         n;
    {h, l, bn, lb, ac, bc} = cfg;
    em   = (!bn && !h && l) ? HSTS_NONE : hsts_mode_e'({1'h0, h, l});
    es   = (ac != 2'h1) ? HSTS_SRC_XTAL : (bc == 2'h1) ? HSTS_SRC_EXT : HSTS_SRC_INT;
    uart = (em == HSTS_ROBOT || em == HSTS_PACKET);
    spi  = (em == HSTS_SPI);
    RST_N_I = 1'h0;
    {hi, lo, boot_n, lsb, a_cfg, b_cfg} = cfg;
    {irq, sda_low, scl_low, miso, tx, hdrv, cs_n} = 7'h09;
    step(16);
    chk(mode, HSTS_NONE, "mode in reset");
    chk({irq_n, data_oe, clk_oe}, 3'h4, "pins in reset");
    RST_N_I = 1'h1;
    polls = 0;
    step(3);
    chk(mode, em, "mode");
    chk(boot_o, !bn, "bootloader flag");
    chk(addr, (em == HSTS_I2C) ? {6'h25, lb} : 7'h00, "target address");
    chk(bitcyc, (em == HSTS_I2C) ? 10'h1F4 : 10'h000, "bit period");
    chk({src_valid, pd_a, pd_b}, 3'h2, "clock straps before sampling");
    // first phase: engine drives, chip selected, host pulls its clock low
    {irq, sda_low, miso, tx, cs_n, hdrv, hval} = 7'h72;
    lsb = !lb;
    step(2);
    chk(irq_n, 1'h0, "interrupt asserted");
    chk(data_oe, em != HSTS_NONE, "data pin enable");
    chk(data_o & data_oe, spi, "data pin value");
    chk(clk_oe, 1'h0, "clock pin enable");
    chk({sda_o, clk_o}, {em != HSTS_I2C, 1'h0}, "data pin level");
    chk({scl_o, sck_o, rx_o}, {em != HSTS_I2C, 1'h0, !uart}, "clock pin low");
    chk({spi_sel, mosi_o, wake_o}, {spi, spi && !lb, spi}, "spi select, data, wake");
    // second phase: deselect, release, and flip the protocol and boot strap pins
    {irq, sda_low, scl_low, tx, cs_n, hdrv} = 6'h0E;
    {hi, lo, boot_n} = {!h, !l, !bn};
    step(2);
    chk(irq_n, 1'h1, "interrupt released");
    chk(data_oe, uart, "data enable deselected");
    chk(data_o & data_oe, uart, "uart transmit");
    chk(sda_o, 1'h1, "data pin released");
    chk(clk_oe, em == HSTS_I2C, "i2c clock pull");
    chk({scl_o, sck_o, rx_o}, {em != HSTS_I2C, spi, 1'h1}, "clock pin high");
    chk({spi_sel, wake_o}, 2'h0, "spi deselected, wake low");
    chk({mode, boot_o}, {em, !bn}, "straps held");
    chk(addr, (em == HSTS_I2C) ? {6'h25, lb} : 7'h00, "address held");
    scl_low = 1'h0;
    n = 7;
    while (src_valid !== 1'h1 && n < 600) begin
      step(1);
      n++;
    end
    chk(n >= ((ac == 2'h1) ? 395 : 195) && n <= ((ac == 2'h1) ? 410 : 210), 1'h1,
        "clock decision time");
    chk(src, es, "clock source");
    chk({pd_a, pd_b, xtal}, {ac != 2'h1, es == HSTS_SRC_INT, es == HSTS_SRC_XTAL},
        "pull-downs after sampling");
    // conflict flag is registered one edge after the clock decision
    step(3);
    chk(conflict, uart && es == HSTS_SRC_INT, "clock conflict flag");
    chk(polls, 1, "aux bus poll pulses");
    $display("test done: straps %0h mode %0d clock %0d", cfg, em, es);
  endtask

  initial begin
    foreach (cases[i]) run_case(cases[i]);
    report_and_stop();
  end
endmodule
